// ### verilog/csa_core.sv
// Module: CPU status register, ALU, return stack and indirect addressing
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Indirect address is pointer byte plus indirect bank bit as ninth bit.
// - Window location has no storage; accesses go to the addressed register.
// - Indirect read with pointer zero returns zero.
// - Indirect write to the window itself changes nothing.
// - Eight-entry return stack, invisible to software, pointer too.
// - Reset leaves the stack pointer at the top of the stack.
// - Call or interrupt pushes PC; return pops the latest entry.
// - Full stack: unmaskable interrupt only flagged, serviced after a pop.
// - Call on full stack drops the oldest entry, keeps eight newest.
// - Eight-bit ALU adds, subtracts, shifts, does logic, updates flags.
// - Work register is internal, unaddressed, reached only by operations.
// - Flag-changing operation to status: written Z, DC, C ignored.
// - Time-out and power-down bits ignore writes.
// - Clear of status zeroes upper three bits, sets Z, keeps rest.
// - Bit 7 picks indirect bank pair: one banks 2-3, zero banks 0-1.
// - Bits 6:5 select direct bank 0 to 3.
// - Bit 2 set when result is zero, cleared otherwise.
// - Bit 1 set on low-nibble carry or no low-nibble borrow.
// - Bit 0 set on carry out or no borrow, else cleared.
// - Time-out bit set by power-on, kick or sleep; cleared by timeout.
// - Power-down bit set by power-on or kick, cleared by sleep.
// - Time-out and power-down pair encodes the cause of the last reset.
module csa_core (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        alu_go,
    input  wire logic [3:0]  alu_op,
    input  wire logic [6:0]  alu_addr,
    input  wire logic        alu_to_file,
    input  wire logic        wdt_kick,
    input  wire logic        sleep_op,
    input  wire logic        wdt_timeout,
    input  wire logic [12:0] pc_now,
    input  wire logic        call_req,
    input  wire logic        ret_req,
    input  wire logic        nmi_req,
    output logic      [12:0] pc_ret,
    output logic             pc_ret_valid,
    output logic             irq_enter,
    output logic             nmi_flag,
    output logic             stack_full
);

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0]  ram [0:csa_pkg::RAM_WORDS-1];
    logic [12:0] stk [0:csa_pkg::STACK_DEPTH-1];
    logic [7:0]  status_reg;
    logic [7:0]  status_next;
    logic [7:0]  pointer_reg;
    logic [7:0]  work_reg;
    logic [2:0]  wp_reg;
    logic [3:0]  depth_reg;
    logic [3:0]  depth_next;

    // ****************************************
    // Address resolution
    // ****************************************
    // Offset 0 resolves through the pointer; any other uses the direct bank
    function automatic logic [8:0] eff_addr(input logic [6:0] a);
        if (a == csa_pkg::OFS_WINDOW) begin
            eff_addr = {status_reg[csa_pkg::BIT_IND_HI], pointer_reg};
        end else begin
            eff_addr = {status_reg[csa_pkg::BIT_BANK_HI:csa_pkg::BIT_BANK_LO], a};
        end
    endfunction

    // Shared registers appear in every bank; the window reads as zero
    function automatic logic [7:0] rd_file(input logic [8:0] e);
        case (e[6:0])
            csa_pkg::OFS_WINDOW:  rd_file = 8'h00;
            csa_pkg::OFS_STATUS:  rd_file = status_reg;
            csa_pkg::OFS_POINTER: rd_file = pointer_reg;
            default:              rd_file = ram[e];
        endcase
    endfunction

    logic [8:0] bus_e;
    logic [8:0] alu_e;
    logic [7:0] alu_a;

    always_comb begin
        bus_e = eff_addr(reg_addr);
        alu_e = eff_addr(alu_addr);
        alu_a = rd_file(alu_e);
    end

    // ****************************************
    // ALU
    // ****************************************
    logic [7:0] alu_res;
    logic       alu_z;
    logic       alu_dc;
    logic       alu_c;
    logic       aff_z;
    logic       aff_dc;
    logic       aff_c;
    logic       res_to_file;
    logic [8:0] sum9;
    logic [4:0] sum5;

    always_comb begin
        sum9        = {1'b0, alu_a} + {1'b0, work_reg};
        sum5        = {1'b0, alu_a[3:0]} + {1'b0, work_reg[3:0]};
        alu_res     = 8'h00;
        alu_dc      = status_reg[csa_pkg::BIT_DC];
        alu_c       = status_reg[csa_pkg::BIT_C];
        aff_z       = 1'b0;
        aff_dc      = 1'b0;
        aff_c       = 1'b0;
        res_to_file = alu_to_file;
        case (alu_op)
            csa_pkg::OP_ADD: begin
                alu_res = sum9[7:0];
                alu_c   = sum9[8];
                alu_dc  = sum5[4];
                aff_z   = 1'b1;
                aff_dc  = 1'b1;
                aff_c   = 1'b1;
            end
            csa_pkg::OP_SUB: begin
                alu_res = alu_a - work_reg;
                alu_c   = (alu_a >= work_reg);
                alu_dc  = (alu_a[3:0] >= work_reg[3:0]);
                aff_z   = 1'b1;
                aff_dc  = 1'b1;
                aff_c   = 1'b1;
            end
            csa_pkg::OP_AND: begin
                alu_res = alu_a & work_reg;
                aff_z   = 1'b1;
            end
            csa_pkg::OP_OR: begin
                alu_res = alu_a | work_reg;
                aff_z   = 1'b1;
            end
            csa_pkg::OP_XOR: begin
                alu_res = alu_a ^ work_reg;
                aff_z   = 1'b1;
            end
            csa_pkg::OP_RLC: begin
                alu_res = {alu_a[6:0], status_reg[csa_pkg::BIT_C]};
                alu_c   = alu_a[7];
                aff_c   = 1'b1;
            end
            csa_pkg::OP_RRC: begin
                alu_res = {status_reg[csa_pkg::BIT_C], alu_a[7:1]};
                alu_c   = alu_a[0];
                aff_c   = 1'b1;
            end
            csa_pkg::OP_CLR: begin
                alu_res     = 8'h00;
                aff_z       = 1'b1;
                res_to_file = 1'b1;
            end
            csa_pkg::OP_LDA: begin
                alu_res     = alu_a;
                aff_z       = 1'b1;
                res_to_file = 1'b0;
            end
            csa_pkg::OP_STA: begin
                alu_res     = work_reg;
                res_to_file = 1'b1;
            end
            default: begin
                res_to_file = 1'b0;
            end
        endcase
        alu_z = (alu_res == 8'h00);
    end

    // ****************************************
    // Write port arbitration
    // ****************************************
    // ALU owns the port when both ask; the bus write is dropped
    logic       alu_file_wr;
    logic       wr_en;
    logic [8:0] wr_e;
    logic [7:0] wr_data;

    always_comb begin
        alu_file_wr = alu_go && res_to_file && (alu_op != csa_pkg::OP_NOP);
        wr_en       = alu_file_wr || (reg_wr && !alu_go);
        wr_e        = alu_file_wr ? alu_e : bus_e;
        wr_data     = alu_file_wr ? alu_res : reg_wdata;
    end

    // Window target means a write with no effect anywhere
    always_ff @(posedge clk_sys) begin
        if (wr_en && (wr_e[6:0] != csa_pkg::OFS_WINDOW) && (wr_e[6:0] != csa_pkg::OFS_STATUS)
            && (wr_e[6:0] != csa_pkg::OFS_POINTER)) begin
            ram[wr_e] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pointer_reg <= csa_pkg::POINTER_RST;
        end else if (wr_en && wr_e[6:0] == csa_pkg::OFS_POINTER) begin
            pointer_reg <= wr_data;
        end
    end

    // Work register has no address; only operations load it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            work_reg <= csa_pkg::WORK_RST;
        end else if (alu_go && !res_to_file && (alu_op != csa_pkg::OP_NOP)) begin
            work_reg <= alu_res;
        end
    end

    // ****************************************
    // Program status
    // ****************************************
    always_comb begin
        status_next = status_reg;
        if (wr_en && wr_e[6:0] == csa_pkg::OFS_STATUS) begin
            if (alu_file_wr && alu_op == csa_pkg::OP_CLR) begin
                status_next[7:5] = 3'h0;
            end else if (alu_file_wr && (aff_z || aff_dc || aff_c)) begin
                status_next[7:5] = wr_data[7:5];
            end else begin
                status_next[7:5] = wr_data[7:5];
                status_next[2:0] = wr_data[2:0];
            end
        end
        if (alu_go) begin
            if (aff_z) begin
                status_next[csa_pkg::BIT_Z] = alu_z;
            end
            if (aff_dc) begin
                status_next[csa_pkg::BIT_DC] = alu_dc;
            end
            if (aff_c) begin
                status_next[csa_pkg::BIT_C] = alu_c;
            end
        end
        if (wdt_kick) begin
            status_next[csa_pkg::BIT_WDT_N] = 1'b1;
            status_next[csa_pkg::BIT_PWR_N] = 1'b1;
        end
        if (sleep_op) begin
            status_next[csa_pkg::BIT_WDT_N] = 1'b1;
            status_next[csa_pkg::BIT_PWR_N] = 1'b0;
        end
        // Timeout last so an expiry is never hidden by a kick in the same cycle
        if (wdt_timeout) begin
            status_next[csa_pkg::BIT_WDT_N] = 1'b0;
        end
    end

    // Reset is power-on: both cause bits come up set
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= csa_pkg::STATUS_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_file(bus_e);
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ****************************************
    // Return stack
    // ****************************************
    // Stack has no port on the register map at all
    logic       nmi_service;
    logic       do_push;
    logic       do_pop;
    logic [2:0] wp_dec;

    always_comb begin
        nmi_service = nmi_flag && (depth_reg != csa_pkg::DEPTH_FULL) && !call_req && !ret_req;
        do_pop      = ret_req;
        do_push     = (call_req && !ret_req) || nmi_service;
        wp_dec      = wp_reg - 3'h1;
        depth_next  = depth_reg;
        if (do_pop) begin
            depth_next = (depth_reg == 4'h0) ? 4'h0 : depth_reg - 4'h1;
        end else if (do_push && depth_reg != csa_pkg::DEPTH_FULL) begin
            depth_next = depth_reg + 4'h1;
        end
    end

    // Circular storage: a push when full overwrites the oldest slot
    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            stk[wp_reg] <= pc_now;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg     <= 3'h0;
            depth_reg  <= 4'h0;
            stack_full <= 1'b0;
        end else begin
            if (do_pop) begin
                wp_reg <= wp_dec;
            end else if (do_push) begin
                wp_reg <= wp_reg + 3'h1;
            end
            depth_reg  <= depth_next;
            stack_full <= (depth_next == csa_pkg::DEPTH_FULL);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pc_ret       <= 13'h0000;
            pc_ret_valid <= 1'b0;
        end else begin
            pc_ret_valid <= do_pop;
            if (do_pop) begin
                pc_ret <= stk[wp_dec];
            end
        end
    end

    // New request wins over the clear of a serviced one
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            nmi_flag  <= 1'b0;
            irq_enter <= 1'b0;
        end else begin
            nmi_flag  <= nmi_req || (nmi_flag && !nmi_service);
            irq_enter <= nmi_service;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    window_zero_a: assert property (
        reg_rd && reg_addr == csa_pkg::OFS_WINDOW && pointer_reg == 8'h00 |=> reg_rdata == 8'h00)
        else $error("window read with zero pointer not zero");

    window_redirect_a: assert property (
        reg_rd && !alu_go && reg_addr == csa_pkg::OFS_WINDOW && pointer_reg == 8'h03
        |=> reg_rdata == $past(status_reg))
        else $error("window read not redirected to status");

    window_write_a: assert property (
        reg_wr && !alu_go && reg_addr == csa_pkg::OFS_WINDOW && pointer_reg == 8'h00
        && !wdt_kick && !sleep_op && !wdt_timeout |=> $stable(status_reg) && $stable(pointer_reg))
        else $error("self window write changed state");

    call_return_a: assert property (
        call_req && !ret_req ##1 ret_req && !call_req |=> pc_ret_valid && pc_ret == $past(pc_now, 2))
        else $error("return did not give back pushed pc");

    nmi_hold_a: assert property (
        depth_reg == csa_pkg::DEPTH_FULL && !ret_req |=> !irq_enter)
        else $error("interrupt serviced with full stack");

    overflow_keep_a: assert property (
        depth_reg == csa_pkg::DEPTH_FULL && call_req && !ret_req |=> depth_reg == csa_pkg::DEPTH_FULL && stack_full)
        else $error("call on full stack changed depth");

    flag_win_a: assert property (
        alu_go && alu_op == csa_pkg::OP_ADD && alu_to_file && alu_e[6:0] == csa_pkg::OFS_STATUS
        |=> status_reg[2:0] == $past({alu_z, alu_dc, alu_c}))
        else $error("status write overrode flags");

    clear_status_a: assert property (
        alu_go && alu_op == csa_pkg::OP_CLR && alu_e[6:0] == csa_pkg::OFS_STATUS
        && !wdt_kick && !sleep_op && !wdt_timeout
        |=> status_reg[7:5] == 3'h0 && status_reg[2] && status_reg[4:0] == {$past(status_reg[4:3]), 1'b1,
            $past(status_reg[1:0])})
        else $error("status clear wrong");

    cause_ro_a: assert property (
        reg_wr && !alu_go && bus_e[6:0] == csa_pkg::OFS_STATUS && !wdt_kick && !sleep_op && !wdt_timeout
        |=> $stable(status_reg[4:3]))
        else $error("cause bits written by software");

    timeout_a: assert property (
        wdt_timeout && !sleep_op && !wdt_kick |=> !status_reg[4] && status_reg[3] == $past(status_reg[3]))
        else $error("timeout did not clear time-out bit only");

    sleep_a: assert property (
        sleep_op && !wdt_timeout |=> status_reg[4] && !status_reg[3])
        else $error("sleep cause bits wrong");

    zero_flag_a: assert property (
        alu_go && alu_op == csa_pkg::OP_XOR && !(alu_to_file && alu_e[6:0] == csa_pkg::OFS_STATUS)
        |=> status_reg[2] == ($past(alu_a) == $past(work_reg)))
        else $error("zero flag mismatch");

    full_call_c: cover property (depth_reg == csa_pkg::DEPTH_FULL && call_req && !ret_req);
    nmi_late_c:  cover property (nmi_flag && stack_full ##1 ret_req ##[1:3] irq_enter);
    ind_wr_c:    cover property (reg_wr && reg_addr == csa_pkg::OFS_WINDOW && pointer_reg != 8'h00);
    clr_st_c:    cover property (alu_go && alu_op == csa_pkg::OP_CLR && alu_e[6:0] == csa_pkg::OFS_STATUS);

endmodule

`default_nettype wire

// ### verilog/csa_pkg.sv
// Package: constants for the status, stack and addressing core
package csa_pkg;

    // ****************************************
    // Widths and sizes
    // ****************************************
    localparam int DATA_W      = 8;
    localparam int ADDR_W      = 7;
    localparam int FULL_W      = 9;
    localparam int PC_W        = 13;
    localparam int STACK_DEPTH = 8;
    localparam int STK_PTR_W   = 3;
    localparam int DEPTH_W     = 4;
    localparam int RAM_WORDS   = 512;

    // ****************************************
    // Register offsets within every bank
    // ****************************************
    localparam logic [6:0] OFS_WINDOW  = 7'h00;
    localparam logic [6:0] OFS_STATUS  = 7'h03;
    localparam logic [6:0] OFS_POINTER = 7'h04;

    // ****************************************
    // Program status fields and reset values
    // ****************************************
    localparam int BIT_IND_HI  = 7;
    localparam int BIT_BANK_HI = 6;
    localparam int BIT_BANK_LO = 5;
    localparam int BIT_WDT_N   = 4;
    localparam int BIT_PWR_N   = 3;
    localparam int BIT_Z       = 2;
    localparam int BIT_DC      = 1;
    localparam int BIT_C       = 0;
    localparam logic [7:0] STATUS_RST  = 8'h18;
    localparam logic [7:0] POINTER_RST = 8'h00;
    localparam logic [7:0] WORK_RST    = 8'h00;
    localparam logic [3:0] DEPTH_FULL  = 4'h8;

    // ****************************************
    // ALU operation codes
    // ****************************************
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_ADD = 4'h1;
    localparam logic [3:0] OP_SUB = 4'h2;
    localparam logic [3:0] OP_AND = 4'h3;
    localparam logic [3:0] OP_OR  = 4'h4;
    localparam logic [3:0] OP_XOR = 4'h5;
    localparam logic [3:0] OP_RLC = 4'h6;
    localparam logic [3:0] OP_RRC = 4'h7;
    localparam logic [3:0] OP_CLR = 4'h8;
    localparam logic [3:0] OP_LDA = 4'h9;
    localparam logic [3:0] OP_STA = 4'hA;

endpackage

// ### verification/csa_core_tb.sv
// Testbench: self-checking scenarios for the status, stack and addressing core
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic        clk_sys;
    logic        rst_n;
    logic [6:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        alu_go;
    logic [3:0]  alu_op;
    logic [6:0]  alu_addr;
    logic        alu_to_file;
    logic        wdt_kick;
    logic        sleep_op;
    logic        wdt_timeout;
    logic [12:0] pc_now;
    logic        call_req;
    logic        ret_req;
    logic        nmi_req;
    logic [12:0] pc_ret;
    logic        pc_ret_valid;
    logic        irq_enter;
    logic        nmi_flag;
    logic        stack_full;
    int          n_mismatch;
    int          tests_run;

    csa_core dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alu_go(alu_go), .alu_op(alu_op), .alu_addr(alu_addr),
        .alu_to_file(alu_to_file), .wdt_kick(wdt_kick), .sleep_op(sleep_op), .wdt_timeout(wdt_timeout),
        .pc_now(pc_now), .call_req(call_req), .ret_req(ret_req), .nmi_req(nmi_req), .pc_ret(pc_ret),
        .pc_ret_valid(pc_ret_valid), .irq_enter(irq_enter), .nmi_flag(nmi_flag), .stack_full(stack_full)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // ****************************************
    // Shared drivers and comparison
    // ****************************************
    task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe edge
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk({5'h00, reg_rdata}, {5'h00, exp}, what);
    endtask

    task automatic alu(input logic [3:0] op, input logic [6:0] a, input logic to_file);
        @(posedge clk_sys);
        alu_go      <= 1'b1;
        alu_op      <= op;
        alu_addr    <= a;
        alu_to_file <= to_file;
        @(posedge clk_sys);
        alu_go      <= 1'b0;
    endtask

    // Kinds: 0 call, 1 return, 2 unmaskable request, 3 kick, 4 sleep, 5 expiry
    task automatic pulse(input int k, input logic [12:0] pc);
        @(posedge clk_sys);
        pc_now      <= pc;
        call_req    <= (k == 0);
        ret_req     <= (k == 1);
        nmi_req     <= (k == 2);
        wdt_kick    <= (k == 3);
        sleep_op    <= (k == 4);
        wdt_timeout <= (k == 5);
        @(posedge clk_sys);
        {call_req, ret_req, nmi_req, wdt_kick, sleep_op, wdt_timeout} <= 6'h00;
        #1;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd_chk(7'h03, 8'h18, "status after reset");
        rd_chk(7'h04, 8'h00, "pointer after reset");
        chk({12'h000, stack_full}, 13'h0000, "stack full after reset");
    endtask

    task automatic t_indirect();
        wr(7'h03, 8'h00);
        wr(7'h30, 8'h5A);
        wr(7'h04, 8'h30);
        rd_chk(7'h00, 8'h5A, "window low bank");
        wr(7'h03, 8'hC0);
        wr(7'h30, 8'hA5);
        wr(7'h03, 8'h80);
        rd_chk(7'h00, 8'hA5, "window high bank");
        rd_chk(7'h30, 8'h5A, "direct bank zero");
        wr(7'h00, 8'h3C);
        wr(7'h03, 8'h40);
        rd_chk(7'h30, 8'h3C, "write through window");
        wr(7'h03, 8'h00);
        wr(7'h04, 8'h03);
        rd_chk(7'h00, 8'h18, "window onto status");
        wr(7'h04, 8'h00);
        rd_chk(7'h00, 8'h00, "window reads itself");
        wr(7'h00, 8'hFF);
        rd_chk(7'h03, 8'h18, "status after void write");
        rd_chk(7'h04, 8'h00, "pointer after void write");
    endtask

    task automatic t_status();
        wr(7'h03, 8'h07);
        rd_chk(7'h03, 8'h1F, "cause bits keep on write");
        // Load work first: the load itself moves the zero flag
        wr(7'h21, 8'h01);
        alu(csa_pkg::OP_LDA, 7'h21, 1'b0);
        wr(7'h03, 8'hE3);
        alu(csa_pkg::OP_CLR, 7'h03, 1'b1);
        rd_chk(7'h03, 8'h1F, "clear of status");
        // Sum is 0x20, so its low bits would read 000 if the flags took it
        alu(csa_pkg::OP_ADD, 7'h03, 1'b1);
        rd_chk(7'h03, 8'h3A, "add into status");
        wr(7'h03, 8'h00);
    endtask

    task automatic t_alu();
        wr(7'h20, 8'h0F);
        alu(csa_pkg::OP_ADD, 7'h20, 1'b1);
        rd_chk(7'h20, 8'h10, "add result");
        rd_chk(7'h03, 8'h1A, "add nibble carry");
        wr(7'h20, 8'hFF);
        alu(csa_pkg::OP_ADD, 7'h20, 1'b1);
        rd_chk(7'h03, 8'h1F, "add wrap flags");
        wr(7'h20, 8'h10);
        alu(csa_pkg::OP_SUB, 7'h20, 1'b0);
        alu(csa_pkg::OP_STA, 7'h22, 1'b1);
        rd_chk(7'h22, 8'h0F, "difference in work");
        rd_chk(7'h03, 8'h19, "sub nibble borrow");
        wr(7'h20, 8'h00);
        alu(csa_pkg::OP_SUB, 7'h20, 1'b1);
        rd_chk(7'h20, 8'hF1, "sub wrap result");
        rd_chk(7'h03, 8'h18, "sub borrow flags");
        alu(csa_pkg::OP_XOR, 7'h22, 1'b1);
        rd_chk(7'h03, 8'h1C, "xor zero flag");
        wr(7'h23, 8'h81);
        alu(csa_pkg::OP_RLC, 7'h23, 1'b1);
        rd_chk(7'h23, 8'h02, "rotate left");
        rd_chk(7'h03, 8'h1D, "rotate left carry");
        alu(csa_pkg::OP_RRC, 7'h23, 1'b1);
        rd_chk(7'h23, 8'h81, "rotate right");
        alu(csa_pkg::OP_AND, 7'h23, 1'b1);
        rd_chk(7'h23, 8'h01, "and result");
        alu(csa_pkg::OP_OR, 7'h23, 1'b0);
        alu(csa_pkg::OP_STA, 7'h24, 1'b1);
        rd_chk(7'h24, 8'h0F, "or result");
        rd_chk(7'h03, 8'h18, "logic clears zero");
        alu(csa_pkg::OP_NOP, 7'h24, 1'b1);
        rd_chk(7'h24, 8'h0F, "no-op keeps file");
        rd_chk(7'h03, 8'h18, "no-op keeps flags");
    endtask

    task automatic t_events();
        pulse(4, 13'h0000);
        rd_chk(7'h03, 8'h10, "after sleep");
        pulse(5, 13'h0000);
        rd_chk(7'h03, 8'h00, "expiry in sleep");
        pulse(3, 13'h0000);
        rd_chk(7'h03, 8'h18, "after kick");
        pulse(5, 13'h0000);
        rd_chk(7'h03, 8'h08, "expiry while running");
    endtask

    task automatic t_stack();
        for (int i = 0; i < 9; i++) pulse(0, 13'h0100 + 13'(i));
        chk({12'h000, stack_full}, 13'h0001, "stack full");
        for (int i = 0; i < 8; i++) begin
            pulse(1, 13'h0000);
            chk({12'h000, pc_ret_valid}, 13'h0001, "pop valid");
            chk(pc_ret, 13'h0108 - 13'(i), "popped address");
        end
        // Call straight into return, no idle cycle between
        @(posedge clk_sys);
        pc_now   <= 13'h1234;
        call_req <= 1'b1;
        @(posedge clk_sys);
        call_req <= 1'b0;
        ret_req  <= 1'b1;
        @(posedge clk_sys);
        ret_req  <= 1'b0;
        #1;
        chk(pc_ret, 13'h1234, "call then return");
        chk({12'h000, stack_full}, 13'h0000, "stack empty again");
    endtask

    task automatic t_nmi();
        int seen;
        seen = 0;
        for (int i = 0; i < 8; i++) pulse(0, 13'h0200 + 13'(i));
        pulse(2, 13'h0ABC);
        // Service must be withheld for as long as no entry is freed
        repeat (3) begin
            @(posedge clk_sys);
            #1;
            chk({11'h000, nmi_flag, irq_enter}, 13'h0002, "held interrupt");
        end
        pulse(1, 13'h0ABC);
        chk(pc_ret, 13'h0207, "pop before service");
        for (int w = 0; w < 4 && seen == 0; w++) begin
            @(posedge clk_sys);
            #1;
            if (irq_enter === 1'b1) seen = 1;
        end
        chk(13'(seen), 13'h0001, "service after pop");
        pulse(1, 13'h0000);
        chk(pc_ret, 13'h0ABC, "interrupt return");
        for (int i = 0; i < 7; i++) begin
            pulse(1, 13'h0000);
            chk(pc_ret, 13'h0206 - 13'(i), "unwind");
        end
    endtask

    // ****************************************
    // Run control
    // ****************************************
    task automatic summarize();
        $display("Comparisons: %0d, mismatches: %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        // Whole run is a few hundred cycles; this leaves wide margin
        #(4 * 5000);
        n_mismatch++;
        $display("Error at %0t: run did not finish", $time);
        summarize();
    end

    initial begin
        n_mismatch = 0;
        tests_run  = 0;
        rst_n = 1'b0;
        {reg_wr, reg_rd, alu_go, alu_to_file, call_req, ret_req, nmi_req} = 7'h00;
        {wdt_kick, sleep_op, wdt_timeout} = 3'h0;
        reg_addr  = 7'h00;
        reg_wdata = 8'h00;
        alu_op    = 4'h0;
        alu_addr  = 7'h00;
        pc_now    = 13'h0000;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_indirect();
        t_status();
        t_alu();
        t_events();
        t_stack();
        t_nmi();
        summarize();
    end
endmodule

`default_nettype wire
